// file: design/dsc_top.sv
// SPI control and status registers of a multi-output load driver
// Operation
// - Control bits 1-17 switch their drivers on
// - PWM enabled drivers conduct only with input high
// - Half bridge never conducts both switches together
// - Test mode muxes internal signals onto data out
// - Over-current sets flag and disables the driver
// - Recovery enable restarts tripped driver after delay
// - Without recovery, driver stays off until cleared
// - Status bit 0 is NOR of bits 1-22
// - Enable bit one selects active mode
// - Enable bit zero: standby, all bits cleared
// - Status word B bit 23 always reads one
// - Reset bit clears status at chip select rise
`timescale 1ns/10ps
`include "dsc_consts.svh"
module dsc_top
#(
  parameter int RECOV12_CYC = `DSC_RECOV_DELAY12_NS / `DSC_CLK_PERIOD_NS,
  parameter int RECOV25_CYC = `DSC_RECOV_DELAY25_NS / `DSC_CLK_PERIOD_NS,
  parameter logic [`DSC_NUM_OUT-1:0] PULSE_INPUT_SECOND_SEL = `DSC_PULSE_INPUT_SECOND_SEL_MASK
)
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic serial_clk_in,
  input wire logic chip_select_pin_n_in,
  input wire logic serial_data_in,
  input wire logic test_mode_in,
  input wire logic pulse_input_first_in,
  input wire logic pulse_input_second_in,
  input wire logic [`DSC_NUM_DRV-1:0] over_current_in,
  output logic serial_data_out,
  output logic serial_data_oe_out,
  output logic [`DSC_NUM_DRV-1:0] driver_on_out,
  output logic active_mode_out
);
  // ****************************************
  // Pin synchronisers
  // ****************************************
  localparam int SW = 6 + `DSC_NUM_DRV;
  logic [SW-1:0] pin_meta_ff;
  logic [SW-1:0] pin_sync_ff;
  wire logic [SW-1:0] pin_raw = {over_current_in, pulse_input_second_in, pulse_input_first_in,
    test_mode_in, serial_data_in, chip_select_pin_n_in, serial_clk_in};
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      pin_meta_ff <= {{(SW-2){1'h0}}, 1'h1, 1'h0};
      pin_sync_ff <= {{(SW-2){1'h0}}, 1'h1, 1'h0};
    end
    else
    begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
    end
  end
  wire logic sclk_s = pin_sync_ff[0];
  wire logic csn_s = pin_sync_ff[1];
  wire logic di_s = pin_sync_ff[2];
  wire logic test_s = pin_sync_ff[3];
  wire logic pulse_input_first_s = pin_sync_ff[4];
  wire logic pulse_input_second_s = pin_sync_ff[5];
  wire logic [`DSC_NUM_DRV-1:0] oc_s = pin_sync_ff[SW-1:6];

  logic sclk_d_ff;
  logic csn_d_ff;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      sclk_d_ff <= 1'h0;
      csn_d_ff <= 1'h1;
    end
    else
    begin
      sclk_d_ff <= sclk_s;
      csn_d_ff <= csn_s;
    end
  end
  wire logic sclk_rise = sclk_s && !sclk_d_ff;
  wire logic sclk_fall = !sclk_s && sclk_d_ff;
  wire logic csn_fall = !csn_s && csn_d_ff;
  wire logic csn_rise = csn_s && !csn_d_ff;

  // ****************************************
  // Serial frame engine
  // ****************************************
  dsc_pkg::dsc_frame_state_type state_ff;
  dsc_pkg::dsc_frame_state_type nxt_state;
  logic [`DSC_FRAME_BITS-1:0] shift_in_ff;
  logic [`DSC_FRAME_BITS-1:0] shift_out_ff;
  logic [`DSC_CNT_W-1:0] bit_cnt_ff;
  logic [`DSC_FRAME_BITS-1:0] ctrl_a_ff;
  logic [`DSC_FRAME_BITS-1:0] ctrl_b_ff;
  dsc_pkg::dsc_reg_sel_type sel_ff;
  logic clr_pulse_ff;
  logic data_ff;
  wire logic [`DSC_NUM_DRV-1:0] flag;
  wire logic [`DSC_NUM_DRV-1:0] trip;
  wire logic [`DSC_NUM_DRV-1:0] drive;

  wire logic shifting = (state_ff == dsc_pkg::DSC_SHIFT);
  wire logic commit = shifting && csn_rise && (bit_cnt_ff == `DSC_FRAME_CNT);
  wire logic frame_sel = shift_in_ff[`DSC_SEL_BIT];
  wire logic commit_a = commit && (frame_sel == dsc_pkg::DSC_SEL_A);
  wire logic commit_b = commit && (frame_sel == dsc_pkg::DSC_SEL_B);
  wire logic go_standby = commit_b && !shift_in_ff[`DSC_ENABLE_BIT];
  wire logic enable = ctrl_b_ff[`DSC_ENABLE_BIT];

  wire logic [`DSC_FRAME_BITS-1:0] status_b;
  wire logic [`DSC_FRAME_BITS-1:0] status_a;
  wire logic no_error = !(|flag) && !(|status_b[`DSC_RESET_BIT:1]);
  assign status_a = {6'h00, flag, no_error};
  assign status_b = {1'h1, 23'h000000};
  wire logic [`DSC_FRAME_BITS-1:0] status_sel = (sel_ff == dsc_pkg::DSC_SEL_B) ? status_b : status_a;

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      dsc_pkg::DSC_IDLE:
        if (csn_fall)
          nxt_state = dsc_pkg::DSC_SHIFT;
      dsc_pkg::DSC_SHIFT:
        if (csn_rise)
          nxt_state = dsc_pkg::DSC_DONE;
      dsc_pkg::DSC_DONE:
        nxt_state = dsc_pkg::DSC_IDLE;
      default:
        nxt_state = dsc_pkg::DSC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_ff <= dsc_pkg::DSC_IDLE;
      shift_in_ff <= `DSC_WORD_ZERO;
      shift_out_ff <= `DSC_WORD_ZERO;
      bit_cnt_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      if (csn_fall)
      begin
        shift_out_ff <= status_sel;
        bit_cnt_ff <= '0;
      end
      else if (shifting && sclk_rise)
      begin
        shift_in_ff <= {shift_in_ff[`DSC_FRAME_BITS-2:0], di_s};
        // Saturate at all ones so overlong frames never commit
        if (bit_cnt_ff != '1)
          bit_cnt_ff <= bit_cnt_ff + 5'h01;
      end
      else if (shifting && sclk_fall)
        shift_out_ff <= {shift_out_ff[`DSC_FRAME_BITS-2:0], 1'h0};
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_a_ff <= `DSC_WORD_ZERO;
      ctrl_b_ff <= `DSC_WORD_ZERO;
      sel_ff <= dsc_pkg::DSC_SEL_A;
      clr_pulse_ff <= 1'h0;
    end
    else
    begin
      clr_pulse_ff <= commit_a && shift_in_ff[`DSC_RESET_BIT];
      if (commit)
        sel_ff <= dsc_pkg::dsc_reg_sel_type'(frame_sel);
      if (go_standby)
      begin
        ctrl_a_ff <= `DSC_WORD_ZERO;
        ctrl_b_ff <= `DSC_WORD_ZERO;
      end
      else if (commit_a)
        ctrl_a_ff <= shift_in_ff;
      else if (commit_b)
        ctrl_b_ff <= shift_in_ff;
    end
  end

  // ****************************************
  // Over-current recovery timer
  // ****************************************
  localparam logic [`DSC_RECOV_W-1:0] R12 = `DSC_RECOV_W'(RECOV12_CYC > 1 ? RECOV12_CYC - 1 : 1);
  localparam logic [`DSC_RECOV_W-1:0] R25 = `DSC_RECOV_W'(RECOV25_CYC > 1 ? RECOV25_CYC - 1 : 1);
  logic [`DSC_RECOV_W-1:0] recov_cnt_ff;
  wire logic [`DSC_RECOV_W-1:0] recov_end = ctrl_a_ff[`DSC_DUTY_BIT] ? R25 : R12;
  wire logic restart = (recov_cnt_ff >= recov_end);
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      recov_cnt_ff <= '0;
    else if (restart)
      recov_cnt_ff <= '0;
    else
      recov_cnt_ff <= recov_cnt_ff + `DSC_RECOV_W'(1);
  end

  // ****************************************
  // Driver channels
  // ****************************************
  wire logic drv_enable = enable && !test_s;
  wire logic flag_clr = clr_pulse_ff || !enable;
  genvar j;
  generate
    for (j = 0; j < `DSC_NUM_DRV; j++)
    begin : g_drv
      localparam int OUT_N = (j < `DSC_NUM_BRIDGE_BITS) ? (j / 2 + 1) : (j - 5);
      localparam bit IN_BRIDGE = (j < `DSC_NUM_BRIDGE_BITS);
      localparam int PEER = IN_BRIDGE ? (j ^ 1) : j;
      wire logic peer_req = IN_BRIDGE ? ctrl_a_ff[PEER+1] : 1'h0;
      wire logic peer_drv = IN_BRIDGE ? drive[PEER] : 1'h0;
      wire logic pwm_lvl = PULSE_INPUT_SECOND_SEL[OUT_N-1] ? pulse_input_second_s : pulse_input_first_s;
      dsc_drv_channel u_chan
      (
        .clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in),
        .enable_in(drv_enable),
        .on_in(ctrl_a_ff[j+1]),
        .pwm_en_in(ctrl_b_ff[OUT_N]),
        .pwm_level_in(pwm_lvl),
        .peer_req_in(peer_req),
        .peer_drive_in(peer_drv),
        .recov_en_in(ctrl_b_ff[`DSC_RECOV_BASE+OUT_N]),
        .restart_in(restart),
        .oc_in(oc_s[j]),
        .flag_clr_in(flag_clr),
        .drive_out(drive[j]),
        .trip_out(trip[j]),
        .flag_out(flag[j])
      );
    end
  endgenerate

  // ****************************************
  // Data out and test multiplexer
  // ****************************************
  wire logic [15:0] test_vec = {oc_s[14:0], enable};
  wire logic [`DSC_TEST_SEL_W-1:0] test_sel = ctrl_a_ff[`DSC_TEST_SEL_LSB +: `DSC_TEST_SEL_W];
  wire logic nxt_data = test_s ? test_vec[test_sel] : shift_out_ff[`DSC_FRAME_BITS-1];
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      data_ff <= 1'h0;
    else
      data_ff <= nxt_data;
  end
  assign serial_data_out = data_ff;
  assign serial_data_oe_out = !csn_s || test_s;
  assign driver_on_out = drive;
  assign active_mode_out = enable;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_write_b(bit v);
    commit_b && (shift_in_ff[`DSC_ENABLE_BIT] == v);
  endsequence
  sequence s_reset_req;
    commit_a && shift_in_ff[`DSC_RESET_BIT] && !(|oc_s);
  endsequence

  a_bridge_exclusive: assert property (!(drive[0] && drive[1]) && !(drive[10] && drive[11]))
    else $error("half bridge both switches on");
  a_on_bit_drive: assert property (drv_enable && ctrl_a_ff[13] && !ctrl_b_ff[7] && !trip[12] && !oc_s[12]
    ##1 drv_enable && ctrl_a_ff[13] && !ctrl_b_ff[7] && !oc_s[12] |=> drive[12])
    else $error("on bit did not switch driver");
  a_pwm_gating: assert property (ctrl_b_ff[7] && !pulse_input_first_s |=> !drive[12])
    else $error("driver conducts with pwm input low");
  a_test_quiet: assert property (test_s |=> drive == `DSC_DRV_ZERO)
    else $error("drivers active in test mode");
  a_oc_trip: assert property (oc_s[12] |=> flag[12] && !drive[12])
    else $error("over-current not flagged or driver still on");
  a_trip_holds: assert property (trip[12] && !ctrl_b_ff[18] && !flag_clr |=> !drive[12])
    else $error("tripped driver restarted without recovery");
  a_no_error: assert property (|flag |-> !status_a[`DSC_NOERR_BIT])
    else $error("no error bit set with a flag active");
  a_enable_set: assert property (s_write_b(1'b1) |=> enable ##1 enable)
    else $error("enable write did not reach active mode");
  a_standby_clear: assert property (s_write_b(1'b0) |=> ctrl_a_ff == `DSC_WORD_ZERO && !enable
    ##1 flag == $past(oc_s))
    else $error("standby write did not clear registers");
  a_reset_state: assert property ($past(sys_rst_in) |-> !enable)
    else $error("active mode right after reset");
  a_frame_marker: assert property (csn_fall && sel_ff == dsc_pkg::DSC_SEL_B |=> shift_out_ff[`DSC_ALWAYS1_BIT])
    else $error("status word B lacks its marker bit");
  a_reset_bit: assert property (s_reset_req ##1 !(|oc_s) |=> flag == '0)
    else $error("reset bit did not clear status");
  a_frame_commit: assert property (commit_a && !go_standby |=> ctrl_a_ff == $past(shift_in_ff))
    else $error("frame not committed at chip select rise");
endmodule : dsc_top

// file: design/dsc_consts.svh
// Constants for the driver SPI control and status block
`ifndef DSC_CONSTS_SVH
`define DSC_CONSTS_SVH
`define DSC_FRAME_BITS 24
`define DSC_CNT_W 5
`define DSC_FRAME_CNT 5'h18
`define DSC_NUM_DRV 17
`define DSC_NUM_OUT 11
`define DSC_NUM_BRIDGE_BITS 12
`define DSC_SEL_BIT 0
`define DSC_NOERR_BIT 0
`define DSC_ENABLE_BIT 23
`define DSC_ALWAYS1_BIT 23
`define DSC_RESET_BIT 22
`define DSC_DUTY_BIT 21
`define DSC_RECOV_BASE 11
`define DSC_TEST_SEL_LSB 1
`define DSC_TEST_SEL_W 4
`define DSC_WORD_ZERO 24'h000000
`define DSC_DRV_ZERO 17'h00000
`define DSC_CLK_PERIOD_NS 10
`define DSC_RECOV_DELAY12_NS 56000
`define DSC_RECOV_DELAY25_NS 24000
`define DSC_RECOV_W 16
`define DSC_PULSE_INPUT_SECOND_SEL_MASK 11'h300
`endif

// file: design/dsc_pkg.sv
// Types for the driver SPI control and status block
package dsc_pkg;
  typedef enum logic [2:0]
  {
    DSC_IDLE  = 3'h1,
    DSC_SHIFT = 3'h2,
    DSC_DONE  = 3'h4
  } dsc_frame_state_type;
  typedef enum logic
  {
    DSC_SEL_A = 1'h0,
    DSC_SEL_B = 1'h1
  } dsc_reg_sel_type;
endpackage : dsc_pkg

// file: design/dsc_drv_channel.sv
// One output driver channel: gating, trip latch and over-current flag
`timescale 1ns/10ps
module dsc_drv_channel
(
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic enable_in,
  input wire logic on_in,
  input wire logic pwm_en_in,
  input wire logic pwm_level_in,
  input wire logic peer_req_in,
  input wire logic peer_drive_in,
  input wire logic recov_en_in,
  input wire logic restart_in,
  input wire logic oc_in,
  input wire logic flag_clr_in,
  output logic drive_out,
  output logic trip_out,
  output logic flag_out
);
  logic drive_ff;
  logic trip_ff;
  logic flag_ff;
  wire logic pwm_ok = !pwm_en_in || pwm_level_in;
  wire logic bridge_ok = !peer_req_in && !peer_drive_in;
  wire logic trip_clr = flag_clr_in || (recov_en_in && restart_in);
  wire logic nxt_trip = oc_in || (trip_ff && !trip_clr);
  wire logic nxt_flag = oc_in || (flag_ff && !flag_clr_in);
  wire logic nxt_drive = enable_in && on_in && pwm_ok && bridge_ok && !nxt_trip;

  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      drive_ff <= 1'h0;
      trip_ff <= 1'h0;
      flag_ff <= 1'h0;
    end
    else
    begin
      drive_ff <= nxt_drive;
      trip_ff <= nxt_trip;
      flag_ff <= nxt_flag;
    end
  end

  assign drive_out = drive_ff;
  assign trip_out = trip_ff;
  assign flag_out = flag_ff;
endmodule : dsc_drv_channel

// file: tb/dsc_spi_master.sv
// Serial master model that frames control words into the driver block
`timescale 1ns/10ps
module dsc_spi_master
(
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  input wire logic miso_in
);
  int bad_cnt = 0;
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  // ****************************************
  // One frame, MSB first, clock idles low
  // ****************************************
  task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
    int i;
    cs_n_out = 1'b0;
    #102;
    for (i = 23; i >= 0; i--)
    begin
      mosi_out = tx[i];
      #61 sclk_out = 1'b1;
      rx[i] = miso_in;
      #64 sclk_out = 1'b0;
    end
    #100 cs_n_out = 1'b1;
    mosi_out = ~tx[0];
    if (rx === 24'h000000 || rx === 24'hFFFFFF)
    begin
      bad_cnt++;
    end
    #100;
  endtask : xfer
endmodule : dsc_spi_master

// file: tb/tb_dsc_top.sv
// Self-checking bench for the driver serial control and status block
`timescale 1ns/10ps
`include "dsc_consts.svh"
module tb_dsc_top;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic test_mode = 1'b0;
  logic pwm_a = 1'b0;
  logic pwm_b = 1'b0;
  logic [`DSC_NUM_DRV-1:0] oc = 17'h00000;
  logic [`DSC_NUM_DRV-1:0] drv;
  logic sclk, cs_n, mosi, miso, sdo, sdo_oe, active;
  logic [23:0] rx;
  int err_count = 0;
  int checks_done = 0;
  int i;
  logic [16:0] rows [6][2] = '{'{17'h00555, 17'h00555}, '{17'h00AAA, 17'h00AAA}, '{17'h1FFFF, 17'h1F000},
    '{17'h10001, 17'h10001}, '{17'h00003, 17'h00000}, '{17'h00AA9, 17'h00AA9}};
  always #5 clk_sys_in = ~clk_sys_in;
  assign miso = sdo_oe ? sdo : ~sdo;
  dsc_spi_master mst_u (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));
  dsc_top #(.RECOV12_CYC(20), .RECOV25_CYC(10)) dut_u
  (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .serial_clk_in(sclk),
    .chip_select_pin_n_in(cs_n),
    .serial_data_in(mosi),
    .test_mode_in(test_mode),
    .pulse_input_first_in(pwm_a),
    .pulse_input_second_in(pwm_b),
    .over_current_in(oc),
    .serial_data_out(sdo),
    .serial_data_oe_out(sdo_oe),
    .driver_on_out(drv),
    .active_mode_out(active)
  );
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic frame(input logic [23:0] tx);
    mst_u.xfer(tx, rx);
    repeat (20) @(negedge clk_sys_in);
  endtask : frame
  task automatic close_out;
    $display("errors=%0d checks=%0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0)
    begin
      $display("bench passed");
    end
    else
    begin
      $display("bench failed");
    end
    $finish;
  endtask : close_out
  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    repeat (12) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    repeat (5) @(negedge clk_sys_in);
    check({7'h00, drv}, 24'h000000);
    check({23'h000000, active}, 24'h000000);
    frame(24'h800001);
    check({23'h000000, active}, 24'h000001);
    for (i = 0; i < 6; i++)
    begin
      frame({6'h00, rows[i][0], 1'b0});
      check({7'h00, drv}, {7'h00, rows[i][1]});
      check(rx, (i == 0) ? 24'h800000 : 24'h000001);
    end
    // Trip output seven without recovery
    frame(24'h002000);
    check({7'h00, drv}, 24'h001000);
    oc[12] = 1'b1;
    repeat (10) @(negedge clk_sys_in);
    check({7'h00, drv}, 24'h000000);
    oc[12] = 1'b0;
    repeat (60) @(negedge clk_sys_in);
    check({7'h00, drv}, 24'h000000);
    frame(24'h402000);
    check(rx, 24'h002000);
    check({7'h00, drv}, 24'h001000);
    frame(24'h002000);
    check(rx, 24'h000001);
    // Pulse gating on output seven
    frame(24'h800081);
    check({7'h00, drv}, 24'h000000);
    pwm_a = 1'b1;
    repeat (10) @(negedge clk_sys_in);
    check({7'h00, drv}, 24'h001000);
    pwm_a = 1'b0;
    repeat (10) @(negedge clk_sys_in);
    check({7'h00, drv}, 24'h000000);
    // Automatic retry after a trip
    frame(24'h840001);
    check({7'h00, drv}, 24'h001000);
    oc[12] = 1'b1;
    repeat (10) @(negedge clk_sys_in);
    check({7'h00, drv}, 24'h000000);
    oc[12] = 1'b0;
    repeat (200) @(negedge clk_sys_in);
    check({7'h00, drv}, 24'h001000);
    // Shorter retry delay with the duty bit set
    frame(24'h202000);
    check({7'h00, drv}, 24'h001000);
    oc[12] = 1'b1;
    repeat (10) @(negedge clk_sys_in);
    check({7'h00, drv}, 24'h000000);
    oc[12] = 1'b0;
    repeat (15) @(negedge clk_sys_in);
    check({7'h00, drv}, 24'h001000);
    // Test mode: enable bit on the data line
    test_mode = 1'b1;
    repeat (10) @(negedge clk_sys_in);
    check({7'h00, drv}, 24'h000000);
    check({22'h000000, sdo_oe, sdo}, 24'h000003);
    test_mode = 1'b0;
    repeat (10) @(negedge clk_sys_in);
    // Standby clears everything
    frame(24'h000001);
    check({23'h000000, active}, 24'h000000);
    check({7'h00, drv}, 24'h000000);
    frame(24'h800001);
    check({7'h00, drv}, 24'h000000);
    check(rx, 24'h800000);
    check(24'(mst_u.bad_cnt), 24'h000000);
    sys_rst_in = 1'b1;
    repeat (3) @(negedge clk_sys_in);
    check({23'h000000, active}, 24'h000000);
    close_out();
  end
  initial
  begin
    #300000;
    err_count++;
    close_out();
  end
endmodule : tb_dsc_top
